//--- src/srcp_top.sv
// Serial remote control port with APB registers
`timescale 1ns/100ps
module srcp_top
  import srcp_pkg::*;
#(
  parameter int DEPTH = 64
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        rxd,
  output logic             txd,
  output logic             rts,
  output logic             device_clear,
  output logic             terminal_mode
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef enum logic [8:0] {
    S_IDLE = 9'b000000001,
    S_ECR  = 9'b000000010,
    S_ELF  = 9'b000000100,
    S_EBUF = 9'b000001000,
    S_DATA = 9'b000010000,
    S_EOL1 = 9'b000100000,
    S_EOL2 = 9'b001000000,
    S_EOF1 = 9'b010000000,
    S_EOF2 = 9'b100000000
  } srcp_st_t;

  // ***************************************
  // Declarations
  // ***************************************
  logic [CFG_W-1:0] cfg_reg;
  logic [1:0]       ctrl_reg;
  logic [17:0]      eof_reg;
  logic [INT_W-1:0] istat_reg;
  logic [INT_W-1:0] ien_reg;
  logic [7:0]       lbuf [DEPTH];
  logic [CW-1:0]    cnt_reg;
  logic [CW-1:0]    rd_reg;
  logic [CW-1:0]    ech_reg;
  logic             line_reg;
  logic             xoff_reg;
  logic [7:0]       txch_reg;
  logic             txpend_reg;
  logic             eolreq_reg;
  logic             eofreq_reg;
  logic             echreq_reg;
  srcp_st_t         st_reg;
  logic             go_reg;
  logic [7:0]       godat_reg;
  logic [DIV_W-1:0] div_reg;
  logic             tick_reg;
  logic             tx_busy;
  logic             rx_valid;
  logic             rx_err;
  logic [7:0]       rx_data;
  logic             setup;
  logic             wr_fire;
  logic             rd_fire;
  logic             active;
  logic             pud;
  logic             data7;
  logic [1:0]       par;
  logic [1:0]       flow;
  logic [1:0]       line_terminator;
  logic [1:0]       eof_cnt;
  logic             full;
  logic             acc;
  logic             is_c;
  logic             is_r;
  logic             is_xon;
  logic             is_xoff;
  logic             is_end;
  logic             is_flow;
  logic             store;
  logic             do_clear;
  logic             can_send;
  logic             pop;
  logic [INT_W-1:0] ev;
  logic [31:0]      rd_mux;
  logic             rd_ok;

  // ***************************************
  // Decode
  // ***************************************
  assign setup   = psel & ~penable;
  assign wr_fire = psel & penable & pready & pwrite;
  assign rd_fire = psel & penable & pready & ~pwrite;
  assign active  = ctrl_reg[CTRL_ACTIVE];
  assign pud     = ctrl_reg[CTRL_PUD];
  assign data7   = cfg_reg[CFG_DATA7];
  assign par     = cfg_reg[CFG_PAR_LO +: 2];
  assign flow    = cfg_reg[CFG_FLOW_LO +: 2];
  assign line_terminator     = cfg_reg[CFG_EOL_LO +: 2];
  assign eof_cnt = eof_reg[EOF_CNT_LO +: 2];
  assign full    = (cnt_reg == CW'(DEPTH));
  assign acc     = rx_valid & ~rx_err & active;
  assign is_c    = acc & (rx_data == CH_CTRL_C);
  assign is_r    = acc & (rx_data == CH_CTRL_R);
  assign is_xon  = acc & (rx_data == CH_XON);
  assign is_xoff = acc & (rx_data == CH_XOFF);
  assign is_end  = acc & (rx_data == CH_CR || rx_data == CH_LF);
  assign is_flow = (is_xon | is_xoff) & (pud | flow == FLOW_XON);
  assign store   = acc & ~is_c & ~is_r & ~is_end & ~is_flow;
  assign do_clear = is_c;
  assign pop     = rd_fire & (paddr == ADDR_RXDATA) & line_reg;
  assign ev[INT_LINE]  = is_end;
  assign ev[INT_CLEAR] = is_c;
  assign ev[INT_ERR]   = rx_valid & rx_err;
  assign ev[INT_OVF]   = store & (line_reg | full);

  // ***************************************
  // Bit rate
  // ***************************************
  // fixed set of rates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg >= baud_div(cfg_reg[CFG_BAUD_LO +: 3]) - DIV_W'(1)) begin
      div_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + DIV_W'(1);
      tick_reg <= 1'b0;
    end
  end

  // ***************************************
  // APB registers
  // ***************************************
  // reset defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg  <= CFG_RST;
      ctrl_reg <= CTRL_RST;
      eof_reg  <= EOF_RST;
      ien_reg  <= '0;
    end else begin
      if (wr_fire && paddr == ADDR_CFG) cfg_reg <= pwdata[CFG_W-1:0];
      if (wr_fire && paddr == ADDR_EOF) eof_reg <= pwdata[17:0];
      if (wr_fire && paddr == ADDR_IEN) ien_reg <= pwdata[INT_W-1:0];
      if (wr_fire && paddr == ADDR_CTRL) begin
        ctrl_reg <= pwdata[1:0];
      end else if (is_end) begin
        ctrl_reg[CTRL_PUD] <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h00000000;
    unique case (paddr)
      ADDR_CFG:    rd_mux[CFG_W-1:0] = cfg_reg;
      ADDR_CTRL:   rd_mux[1:0] = ctrl_reg;
      ADDR_STATUS: begin
        rd_mux[0] = line_reg;
        rd_mux[1] = txpend_reg;
        rd_mux[2] = tx_busy;
        rd_mux[3] = xoff_reg;
        rd_mux[4] = rts;
        rd_mux[5] = full;
        rd_mux[ST_CNT_LO +: CW] = cnt_reg;
      end
      ADDR_RXDATA: begin
        rd_mux[7:0]       = lbuf[rd_reg[CW-2:0]];
        rd_mux[RXD_VALID] = line_reg;
      end
      ADDR_ISTAT:  rd_mux[INT_W-1:0] = istat_reg;
      ADDR_IEN:    rd_mux[INT_W-1:0] = ien_reg;
      ADDR_EOF:    rd_mux[17:0] = eof_reg;
      ADDR_TXDATA, ADDR_TXCMD, ADDR_ICLR: rd_mux = 32'h00000000;
      default:     rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata  <= rd_mux;
        pslverr <= ~rd_ok;
      end
    end
  end

  // ***************************************
  // Interrupts
  // ***************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_reg <= '0;
      irq       <= 1'b0;
    end else begin
      if (wr_fire && paddr == ADDR_ICLR) begin
        istat_reg <= (istat_reg & ~pwdata[INT_W-1:0]) | ev;
      end else begin
        istat_reg <= istat_reg | ev;
      end
      irq <= |(istat_reg & ien_reg);
    end
  end

  // ***************************************
  // Line buffer
  // ***************************************
  always_ff @(posedge pclk) begin
    if (store && !line_reg && !full) lbuf[cnt_reg[CW-2:0]] <= rx_data;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= '0;
      rd_reg   <= '0;
      line_reg <= 1'b0;
    end else if (do_clear) begin
      cnt_reg  <= '0;
      rd_reg   <= '0;
      line_reg <= 1'b0;
    end else if (pop) begin
      if (rd_reg + CW'(1) == cnt_reg) begin
        cnt_reg  <= '0;
        rd_reg   <= '0;
        line_reg <= 1'b0;
      end else begin
        rd_reg <= rd_reg + CW'(1);
      end
    end else if (is_end && !line_reg && cnt_reg != '0) begin
      line_reg <= 1'b1;
    end else if (store && !line_reg && !full) begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  // ***************************************
  // Flow control and pins
  // ***************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xoff_reg      <= 1'b0;
      rts           <= 1'b1;
      device_clear  <= 1'b0;
      terminal_mode <= 1'b0;
    end else begin
      if (flow != FLOW_XON || is_xon || do_clear) xoff_reg <= 1'b0;
      else if (is_xoff) xoff_reg <= 1'b1;
      rts <= (flow == FLOW_RTS) ? ~(line_reg | full) : 1'b1;
      device_clear  <= do_clear;
      terminal_mode <= cfg_reg[CFG_TERM];
    end
  end

  // ***************************************
  // Transmit sequencing
  // ***************************************
  assign can_send = ~tx_busy & ~go_reg & ~xoff_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txch_reg   <= 8'h00;
      txpend_reg <= 1'b0;
      eolreq_reg <= 1'b0;
      eofreq_reg <= 1'b0;
      echreq_reg <= 1'b0;
      ech_reg    <= '0;
      st_reg     <= S_IDLE;
      go_reg     <= 1'b0;
      godat_reg  <= 8'h00;
    end else if (do_clear) begin
      txpend_reg <= 1'b0;
      eolreq_reg <= 1'b0;
      eofreq_reg <= 1'b0;
      echreq_reg <= 1'b0;
      st_reg     <= S_IDLE;
      go_reg     <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      if (wr_fire && paddr == ADDR_TXDATA && !txpend_reg) begin
        txch_reg   <= pwdata[7:0];
        txpend_reg <= 1'b1;
      end
      if (wr_fire && paddr == ADDR_TXCMD) begin
        if (pwdata[CMD_EOL]) eolreq_reg <= 1'b1;
        if (pwdata[CMD_EOF]) eofreq_reg <= 1'b1;
      end
      if (is_r && !line_reg) echreq_reg <= 1'b1;
      unique case (st_reg)
        S_IDLE: begin
          if (echreq_reg) begin
            echreq_reg <= 1'b0;
            st_reg     <= S_ECR;
          end else if (txpend_reg) begin
            st_reg <= S_DATA;
          end else if (eolreq_reg) begin
            eolreq_reg <= 1'b0;
            st_reg     <= S_EOL1;
          end else if (eofreq_reg) begin
            eofreq_reg <= 1'b0;
            st_reg     <= S_EOF1;
          end
        end
        S_ECR: if (can_send) begin
          go_reg    <= 1'b1;
          godat_reg <= CH_CR;
          st_reg    <= S_ELF;
        end
        S_ELF: if (can_send) begin
          go_reg    <= 1'b1;
          godat_reg <= CH_LF;
          ech_reg   <= '0;
          st_reg    <= S_EBUF;
        end
        S_EBUF: if (can_send) begin
          if (ech_reg >= cnt_reg) begin
            st_reg <= S_IDLE;
          end else begin
            go_reg    <= 1'b1;
            godat_reg <= lbuf[ech_reg[CW-2:0]];
            ech_reg   <= ech_reg + CW'(1);
          end
        end
        S_DATA: if (can_send) begin
          go_reg     <= 1'b1;
          godat_reg  <= txch_reg;
          txpend_reg <= 1'b0;
          st_reg     <= S_IDLE;
        end
        S_EOL1: if (can_send) begin
          go_reg    <= 1'b1;
          godat_reg <= (line_terminator == EOL_LF) ? CH_LF : CH_CR;
          st_reg    <= (line_terminator == EOL_CR || line_terminator == EOL_LF) ? S_IDLE : S_EOL2;
        end
        S_EOL2: if (can_send) begin
          go_reg    <= 1'b1;
          godat_reg <= CH_LF;
          st_reg    <= S_IDLE;
        end
        S_EOF1: if (can_send) begin
          go_reg    <= (eof_cnt != 2'h0);
          godat_reg <= eof_reg[7:0];
          st_reg    <= (eof_cnt >= 2'h2) ? S_EOF2 : S_IDLE;
        end
        S_EOF2: if (can_send) begin
          go_reg    <= 1'b1;
          godat_reg <= eof_reg[15:8];
          st_reg    <= S_IDLE;
        end
      endcase
    end
  end

  // ***************************************
  // Serial engines
  // ***************************************
  srcp_tx u_tx (
    .pclk    (pclk),
    .presetn (presetn),
    .tick16  (tick_reg),
    .go      (go_reg),
    .data    (godat_reg),
    .data7   (data7),
    .stop2   (cfg_reg[CFG_STOP2]),
    .parity  (par),
    .busy    (tx_busy),
    .txd     (txd)
  );

  srcp_rx u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .tick16  (tick_reg),
    .rxd     (rxd),
    .data7   (data7),
    .parity  (par),
    .valid   (rx_valid),
    .err     (rx_err),
    .data    (rx_data)
  );
endmodule

//--- src/srcp_pkg.sv
// Constants and helpers for the serial remote control port
// What this block does
// - Data width is 7 or 8 bits, 8 after reset
// - One or two stop bits, one after reset
// - Parity odd, even or none, none after reset
// - Rates 9600 to 115200 baud only, 9600 after reset
// - Flow control XON/XOFF, RTS or none, XON/XOFF after reset
// - Output lines end with CR, LF or CR LF, CR LF default
// - Received CR or LF alone ends a command line
// - Up to two end-of-file characters, none sent by default
// - Control-C causes a device clear
// - Control-R echoes CR, LF and the pending line
// - Protected data capture never stores special characters; acts on them, except XON/XOFF unless XON/XOFF flow control is set
// - Protected data capture ends at CR or LF
// - No service request signal; status keeps updating
// - One setting selects terminal or computer mode
// - Commands accepted only while serial port is the active port
package srcp_pkg;
  // ***************************************
  // Timing
  // ***************************************
  localparam int         CLK_HZ     = 200_000_000;
  localparam int         OVERSAMPLE = 16;
  localparam int         DIV_W      = 12;
  localparam logic [3:0] OS_LAST    = 4'hf;
  localparam logic [3:0] OS_MID     = 4'h7;
  localparam int         BAUD_0     = 9600;
  localparam int         BAUD_1     = 19200;
  localparam int         BAUD_2     = 38400;
  localparam int         BAUD_3     = 57600;
  localparam int         BAUD_4     = 115200;
  // ***************************************
  // Register map
  // ***************************************
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0c;
  localparam logic [7:0] ADDR_TXCMD  = 8'h10;
  localparam logic [7:0] ADDR_RXDATA = 8'h14;
  localparam logic [7:0] ADDR_ISTAT  = 8'h18;
  localparam logic [7:0] ADDR_IEN    = 8'h1c;
  localparam logic [7:0] ADDR_ICLR   = 8'h20;
  localparam logic [7:0] ADDR_EOF    = 8'h24;
  localparam int CFG_DATA7   = 0;
  localparam int CFG_STOP2   = 1;
  localparam int CFG_PAR_LO  = 2;
  localparam int CFG_BAUD_LO = 4;
  localparam int CFG_FLOW_LO = 7;
  localparam int CFG_EOL_LO  = 9;
  localparam int CFG_TERM    = 11;
  localparam int CFG_W       = 12;
  localparam logic [CFG_W-1:0] CFG_RST = 12'h000;
  localparam int CTRL_ACTIVE = 0;
  localparam int CTRL_PUD    = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int CMD_EOL = 0;
  localparam int CMD_EOF = 1;
  localparam int EOF_CNT_LO = 16;
  localparam logic [17:0] EOF_RST = 18'h00000;
  localparam int RXD_VALID = 8;
  localparam int ST_CNT_LO = 16;
  localparam int INT_LINE  = 0;
  localparam int INT_CLEAR = 1;
  localparam int INT_ERR   = 2;
  localparam int INT_OVF   = 3;
  localparam int INT_W     = 4;
  // ***************************************
  // Encodings
  // ***************************************
  localparam logic [1:0] PAR_NONE  = 2'h0;
  localparam logic [1:0] PAR_ODD   = 2'h1;
  localparam logic [1:0] PAR_EVEN  = 2'h2;
  localparam logic [1:0] FLOW_XON  = 2'h0;
  localparam logic [1:0] FLOW_RTS  = 2'h1;
  localparam logic [1:0] FLOW_NONE = 2'h2;
  localparam logic [1:0] EOL_CRLF  = 2'h0;
  localparam logic [1:0] EOL_CR    = 2'h1;
  localparam logic [1:0] EOL_LF    = 2'h2;
  localparam logic [7:0] CH_CTRL_C = 8'h03;
  localparam logic [7:0] CH_CTRL_R = 8'h12;
  localparam logic [7:0] CH_XON    = 8'h11;
  localparam logic [7:0] CH_XOFF   = 8'h13;
  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_LF     = 8'h0a;

  function automatic logic par_bit(logic [7:0] d, logic data7, logic [1:0] mode);
    logic x;
    x = ^(data7 ? {1'b0, d[6:0]} : d);
    return (mode == PAR_ODD) ? ~x : x;
  endfunction

  function automatic logic [DIV_W-1:0] baud_div(logic [2:0] sel);
    case (sel)
      3'h1:    return DIV_W'(CLK_HZ / (OVERSAMPLE * BAUD_1));
      3'h2:    return DIV_W'(CLK_HZ / (OVERSAMPLE * BAUD_2));
      3'h3:    return DIV_W'(CLK_HZ / (OVERSAMPLE * BAUD_3));
      3'h4:    return DIV_W'(CLK_HZ / (OVERSAMPLE * BAUD_4));
      default: return DIV_W'(CLK_HZ / (OVERSAMPLE * BAUD_0));
    endcase
  endfunction
endpackage

//--- src/srcp_tx.sv
// Character transmitter with programmable framing
`timescale 1ns/100ps
module srcp_tx
  import srcp_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick16,
  input  wire logic       go,
  input  wire logic [7:0] data,
  input  wire logic       data7,
  input  wire logic       stop2,
  input  wire logic [1:0] parity,
  output logic            busy,
  output logic            txd
);
  typedef enum logic [4:0] {
    T_IDLE  = 5'b00001,
    T_START = 5'b00010,
    T_DATA  = 5'b00100,
    T_PAR   = 5'b01000,
    T_STOP  = 5'b10000
  } srcp_tx_st_t;

  srcp_tx_st_t st_reg;
  logic [3:0]  sub_reg;
  logic [2:0]  idx_reg;
  logic [7:0]  sh_reg;
  logic        par_reg;
  logic        stp_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg  <= T_IDLE;
      sub_reg <= 4'h0;
      idx_reg <= 3'h0;
      sh_reg  <= 8'h00;
      par_reg <= 1'b0;
      stp_reg <= 1'b0;
      busy    <= 1'b0;
      txd     <= 1'b1;
    end else if (st_reg == T_IDLE) begin
      if (go) begin
        st_reg  <= T_START;
        sh_reg  <= data;
        par_reg <= par_bit(data, data7, parity);
        sub_reg <= 4'h0;
        busy    <= 1'b1;
        txd     <= 1'b0;
      end
    end else if (tick16) begin
      sub_reg <= sub_reg + 4'h1;
      if (sub_reg == OS_LAST) begin
        unique case (st_reg)
          T_START: begin
            st_reg  <= T_DATA;
            idx_reg <= 3'h0;
            txd     <= sh_reg[0];
          end
          T_DATA: begin
            sh_reg <= sh_reg >> 1;
            if (idx_reg == (data7 ? 3'h6 : 3'h7)) begin
              if (parity == PAR_ODD || parity == PAR_EVEN) begin
                st_reg <= T_PAR;
                txd    <= par_reg;
              end else begin
                st_reg  <= T_STOP;
                stp_reg <= 1'b0;
                txd     <= 1'b1;
              end
            end else begin
              idx_reg <= idx_reg + 3'h1;
              txd     <= sh_reg[1];
            end
          end
          T_PAR: begin
            st_reg  <= T_STOP;
            stp_reg <= 1'b0;
            txd     <= 1'b1;
          end
          T_STOP: begin
            if (stp_reg == stop2) begin
              st_reg <= T_IDLE;
              busy   <= 1'b0;
            end else begin
              stp_reg <= 1'b1;
            end
          end
          T_IDLE: ;
        endcase
      end
    end
  end
endmodule

//--- src/srcp_rx.sv
// Character receiver, 16x oversampled
`timescale 1ns/100ps
module srcp_rx
  import srcp_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick16,
  input  wire logic       rxd,
  input  wire logic       data7,
  input  wire logic [1:0] parity,
  output logic            valid,
  output logic            err,
  output logic [7:0]      data
);
  typedef enum logic [4:0] {
    R_IDLE  = 5'b00001,
    R_START = 5'b00010,
    R_DATA  = 5'b00100,
    R_PAR   = 5'b01000,
    R_STOP  = 5'b10000
  } srcp_rx_st_t;

  srcp_rx_st_t st_reg;
  logic [3:0]  sub_reg;
  logic [2:0]  idx_reg;
  logic        perr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg   <= R_IDLE;
      sub_reg  <= 4'h0;
      idx_reg  <= 3'h0;
      perr_reg <= 1'b0;
      valid    <= 1'b0;
      err      <= 1'b0;
      data     <= 8'h00;
    end else begin
      valid <= 1'b0;
      if (tick16) begin
        sub_reg <= sub_reg + 4'h1;
        unique case (st_reg)
          R_IDLE: begin
            sub_reg <= 4'h0;
            if (!rxd) st_reg <= R_START;
          end
          R_START: begin
            if (sub_reg == OS_MID) begin
              sub_reg  <= 4'h0;
              idx_reg  <= 3'h0;
              data     <= 8'h00;
              perr_reg <= 1'b0;
              st_reg   <= rxd ? R_IDLE : R_DATA;
            end
          end
          R_DATA: begin
            if (sub_reg == OS_LAST) begin
              data[idx_reg] <= rxd;
              idx_reg       <= idx_reg + 3'h1;
              if (idx_reg == (data7 ? 3'h6 : 3'h7)) begin
                st_reg <= (parity == PAR_ODD || parity == PAR_EVEN) ? R_PAR : R_STOP;
              end
            end
          end
          R_PAR: begin
            if (sub_reg == OS_LAST) begin
              perr_reg <= (rxd != par_bit(data, data7, parity));
              st_reg   <= R_STOP;
            end
          end
          R_STOP: begin
            if (sub_reg == OS_LAST) begin
              valid  <= 1'b1;
              err    <= perr_reg | ~rxd;
              st_reg <= R_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule

//--- dv/srcp_properties.sv
// Checker for the serial remote control port
`timescale 1ns/100ps
module srcp_properties
  import srcp_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        device_clear,
  input wire logic        terminal_mode
);
  logic setup;
  logic wr_cfg;
  assign setup  = psel && !penable;
  assign wr_cfg = psel && penable && pready && pwrite && paddr == ADDR_CFG;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_dclr_pulse: assert property (device_clear |=> !device_clear)
    else $error("device clear longer than one cycle");
  a_dclr_stop: assert property (device_clear |-> rxd)
    else $error("device clear outside stop bit");
  a_term_mode: assert property (wr_cfg |-> ##2 terminal_mode == $past(pwdata[11], 2))
    else $error("terminal mode not following setting");
  a_start_bit: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit too short");
  a_ready_acc: assert property (psel && penable |-> pready)
    else $error("access not answered");
  a_bad_addr: assert property (setup && paddr > ADDR_EOF |=> pslverr)
    else $error("unmapped address not refused");
  a_good_addr: assert property (setup && paddr <= ADDR_EOF && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped address refused");
  a_wo_read: assert property (setup && !pwrite && paddr == ADDR_TXDATA |=> prdata == 32'h0)
    else $error("write-only register reads nonzero");
endmodule
bind srcp_top srcp_properties u_props (.*);

//--- dv/srcp_host.sv
// Serial host model facing the port
`timescale 1ns/100ps
module srcp_host
  import srcp_pkg::*;
(
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd
);
  localparam int BIT = OVERSAMPLE * (CLK_HZ / (OVERSAMPLE * BAUD_4));
  logic stop_ok;
  initial rxd = 1'h1;
  // eight bits, no parity, one stop
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'h1, d, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge pclk);
    end
  endtask
  task automatic recv(output logic [7:0] d);
    while (txd !== 1'h0) @(posedge pclk);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge pclk);
      d[i] = txd;
    end
    repeat (BIT) @(posedge pclk);
    stop_ok = txd;
  endtask
endmodule

//--- dv/tb.sv
// Self-checking bench for the serial remote control port
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module tb
  import srcp_pkg::*;
;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00, rx_byte;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic        er, pready, pslverr, irq, rxd, txd, rts, device_clear, terminal_mode;
  logic        dclr_seen = 1'h0;
  int          err_total = 0, total_checks = 0, cyc = 0;
  initial forever #2.5 pclk = ~pclk;
  srcp_top #(.DEPTH(64)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .rxd(rxd), .txd(txd), .rts(rts),
    .device_clear(device_clear), .terminal_mode(terminal_mode));
  srcp_host u_host (.pclk(pclk), .txd(txd), .rxd(rxd));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    apb(1'h0, ADDR_CFG, 32'h0);
    `CHK("cfg reset", 32'h0, rd)
    apb(1'h0, ADDR_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h1, rd)
    apb(1'h0, 8'h30, 32'h0);
    `CHK("unmapped err", 1'h1, er)
    apb(1'h0, ADDR_TXDATA, 32'h0);
    `CHK("terminal reset", 1'h0, terminal_mode)
    $display("t_reset done");
  endtask
  task automatic t_config();
    apb(1'h1, ADDR_CFG, 32'h840);
    apb(1'h0, ADDR_CFG, 32'h0);
    `CHK("cfg readback", 32'h840, rd)
    `CHK("terminal set", 1'h1, terminal_mode)
    apb(1'h1, ADDR_IEN, 32'h3);
    $display("t_config done");
  endtask
  task automatic t_ctrlc();
    u_host.send(CH_CTRL_C);
    `CHK("device clear", 1'h1, dclr_seen)
    `CHK("irq raised", 1'h1, irq)
    apb(1'h0, ADDR_ISTAT, 32'h0);
    `CHK("clear status", 1'h1, rd[1])
    apb(1'h1, ADDR_ICLR, 32'h2);
    repeat (3) @(posedge pclk);
    `CHK("irq cleared", 1'h0, irq)
    $display("t_ctrlc done");
  endtask
  task automatic t_line();
    apb(1'h1, ADDR_CFG, 32'h8c0);
    u_host.send(8'h41);
    u_host.send(CH_CR);
    apb(1'h0, ADDR_STATUS, 32'h0);
    `CHK("line ready", 1'h1, rd[0])
    `CHK("rts held", 1'h0, rts)
    apb(1'h0, ADDR_RXDATA, 32'h0);
    `CHK("rx char", 9'h141, rd[8:0])
    apb(1'h0, ADDR_ISTAT, 32'h0);
    `CHK("line event", 1'h1, rd[0])
    `CHK("rts freed", 1'h1, rts)
    $display("t_line done");
  endtask
  task automatic t_tx();
    apb(1'h1, ADDR_TXDATA, 32'h5a);
    u_host.recv(rx_byte);
    `CHK("tx char", 8'h5a, rx_byte)
    `CHK("tx stop", 1'h1, u_host.stop_ok)
    $display("t_tx done");
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (device_clear === 1'h1) dclr_seen <= 1'h1;
    if (cyc == 90000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_config();
    t_ctrlc();
    t_line();
    t_tx();
    test_done();
  end
endmodule
